/* File: design/dbc_breakpoint_unit.sv */
// Purpose: breakpoint comparators and trigger sequencer of a core
// Assumes: pc, local bus and trigger configuration share ref_clk
// Notes: trigger follows the match one cycle later; a one-cycle pulse in two-level mode

`timescale 1ns/100ps

// Overview of operation
// - first pc register compared bit by bit with pc, mask bits exclude.
// - mask applies only to first pc register; others compare whole address.
// - other pc registers hold address in 31..1, enable flag in bit 0.
// - mask bit 0 keeps address bit in compare, 1 ignores it.
// - low and high registers compared against every local bus address.
// - address match is equal-low, inside inclusive range, or outside range.
// - low and high registers hold full 32 bits; low gives single address.
// - data pattern compared bit by bit; mask 1 drops that bit.
// - byte accesses compare the lane chosen by address bits 1 to 0.
// - word uses lane by address bit 1; longword uses whole bus.
// - one-level trigger on pc, pc or address, or address alone.
// - two-level trigger waits for one condition, then fires on the other.
// - pc term is OR of masked first and three unmasked matches.
// - address term uses low, high, attribute; data only qualifies address.
// - registers written by supervisor debug write or debugger command.
// - pc invert bit selects match inside or outside the masked region.
// - three enables choose single, range or outside; none disables.
// - data invert bit flips the sense of the one masked data compare result.
// - pc enable bit turns the pc term on or off.
module dbc_breakpoint_unit
  import dbc_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // privileged debug write instruction from the core
  input wire logic privWrValid,
  input wire logic supervisorMode,
  input wire logic [DBC_SELW-1:0] privWrSel,
  input wire logic [DBC_DW-1:0] privWrData,
  // debugger register write command from the debug port
  input wire logic dbgWrValid,
  input wire logic [DBC_SELW-1:0] dbgWrSel,
  input wire logic [DBC_DW-1:0] dbgWrData,
  // trigger definition bits
  input wire logic pcMatchInvert,
  input wire logic pcMatchEnable,
  input wire logic [2:0] addrMatchEnables,
  input wire logic dataMatchInvert,
  input wire logic dataMatchEnable,
  input wire logic twoLevelEnable,
  input wire logic twoLevelPcFirst,
  input wire logic cfgWrite,
  // address attribute qualification
  input wire logic addrAttrMatch,
  // executing program counter
  input wire logic pcValid,
  input wire logic [DBC_AW-1:0] pcValue,
  // local bus transfer
  input wire logic busValid,
  input wire logic [DBC_AW-1:0] busAddr,
  input wire logic [1:0] busSize,
  input wire logic [DBC_DW-1:0] busData,
  // results
  output logic privWrRefused,
  output logic debugTrigger,
  output logic [1:0] trigStage
);

  ////////////////////////////////////////////////////////////////////////////
  // register write path

  logic [DBC_DW-1:0] pcAddrReg [DBC_NPC];
  logic [DBC_DW-1:0] pcMaskReg;
  logic [DBC_AW-1:0] addrLowReg;
  logic [DBC_AW-1:0] addrHighReg;
  logic [DBC_DW-1:0] dataValueReg;
  logic [DBC_DW-1:0] dataMaskReg;

  wire logic privWrOk;
  wire logic wrEn;
  wire logic [DBC_SELW-1:0] wrSel;
  wire logic [DBC_DW-1:0] wrData;

  // only supervisor mode or the debugger may write
  assign privWrOk = privWrValid & supervisorMode;
  assign privWrRefused = privWrValid & ~supervisorMode;
  assign wrEn = privWrOk | dbgWrValid;
  // debugger wins when both write in one cycle
  assign wrSel = dbgWrValid ? dbgWrSel : privWrSel;
  assign wrData = dbgWrValid ? dbgWrData : privWrData;

  wire logic wrPc0 = wrEn & (wrSel == SEL_PC_MASKED);
  wire logic wrPc1 = wrEn & (wrSel == SEL_PC_VALID1);
  wire logic wrPc2 = wrEn & (wrSel == SEL_PC_VALID2);
  wire logic wrPc3 = wrEn & (wrSel == SEL_PC_VALID3);
  wire logic wrPcMask = wrEn & (wrSel == SEL_PC_MASK);
  wire logic wrAddrLow = wrEn & (wrSel == SEL_ADDR_LOW);
  wire logic wrAddrHigh = wrEn & (wrSel == SEL_ADDR_HIGH);
  wire logic wrDataValue = wrEn & (wrSel == SEL_DATA_VALUE);
  wire logic wrDataMask = wrEn & (wrSel == SEL_DATA_MASK);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pcAddrReg[0] <= REG_RESET;
      pcAddrReg[1] <= REG_RESET;
      pcAddrReg[2] <= REG_RESET;
      pcAddrReg[3] <= REG_RESET;
    end else begin
      if (wrPc0) pcAddrReg[0] <= wrData;
      if (wrPc1) pcAddrReg[1] <= wrData;
      if (wrPc2) pcAddrReg[2] <= wrData;
      if (wrPc3) pcAddrReg[3] <= wrData;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pcMaskReg <= REG_RESET;
      addrLowReg <= REG_RESET;
      addrHighReg <= REG_RESET;
    end else begin
      if (wrPcMask) pcMaskReg <= wrData;
      if (wrAddrLow) addrLowReg <= wrData;
      if (wrAddrHigh) addrHighReg <= wrData;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dataValueReg <= REG_RESET;
      dataMaskReg <= REG_RESET;
    end else begin
      if (wrDataValue) dataValueReg <= wrData;
      if (wrDataMask) dataMaskReg <= wrData;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // program counter comparators

  logic [DBC_NPC-1:0] pcHitVec;

  for (genvar i = 0; i < DBC_NPC; i++) begin : g_pc
    wire logic [DBC_AW-1:0] ignoreBits;
    wire logic cmpEnable;
    if (i == 0) begin : g_masked
      // masked register has no enable flag; bit 0 is left to software
      assign ignoreBits = pcMaskReg;
      assign cmpEnable = 1'b1;
    end else begin : g_valid
      // unmasked: whole address 31..1, gated by its enable flag
      assign ignoreBits = PCV_IGNORE;
      assign cmpEnable = pcAddrReg[i][PCV_VALID_BIT];
    end
    dbc_pc_cmp u_cmp (
      .pcValue(pcValue),
      .breakAddr(pcAddrReg[i]),
      .ignoreMask(ignoreBits),
      .enable(cmpEnable),
      .hit(pcHitVec[i])
    );
  end

  wire logic pcHit0 = pcHitVec[0] ^ pcMatchInvert;
  wire logic pcHitAny = pcHit0 | (|pcHitVec[DBC_NPC-1:1]);
  wire logic pcTerm = pcValid & pcMatchEnable & pcHitAny;

  ////////////////////////////////////////////////////////////////////////////
  // address comparators

  wire logic addrEqLow = (busAddr == addrLowReg);
  wire logic addrAboveLow = (busAddr >= addrLowReg);
  wire logic addrBelowHigh = (busAddr <= addrHighReg);
  wire logic addrInRange = addrAboveLow & addrBelowHigh;

  // all enables clear gives no address match
  wire logic addrSel =
    (addrMatchEnables[AEN_LOW] & addrEqLow) |
    (addrMatchEnables[AEN_RANGE] & addrInRange) |
    (addrMatchEnables[AEN_OUTSIDE] & ~addrInRange);
  // every local bus transfer is checked
  wire logic addrHit = busValid & addrAttrMatch & addrSel;

  ////////////////////////////////////////////////////////////////////////////
  // data comparator

  logic [DBC_DW-1:0] laneMask;

  always_comb begin
    case (busSize)
      SIZE_BYTE: begin
        case (busAddr[1:0])
          2'h0: laneMask = LANE_B0;
          2'h1: laneMask = LANE_B1;
          2'h2: laneMask = LANE_B2;
          default: laneMask = LANE_B3;
        endcase
      end
      SIZE_WORD: begin
        laneMask = busAddr[1] ? LANE_WLO : LANE_WHI;
      end
      default: begin
        laneMask = LANE_ALL;
      end
    endcase
  end

  wire logic [DBC_DW-1:0] dataDiff =
    (busData ^ dataValueReg) & ~dataMaskReg & laneMask;
  wire logic dataHit = (dataDiff == '0) ^ dataMatchInvert;
  wire logic dataQual = ~dataMatchEnable | dataHit;
  // data never stands alone, only narrows the address term
  wire logic addrTerm = addrHit & dataQual;

  ////////////////////////////////////////////////////////////////////////////
  // trigger sequencer

  dbc_state_e state_reg;
  dbc_state_e state_next;
  logic trigger_reg;
  logic trigger_next;

  wire logic oneLevelFire = pcTerm | addrTerm;
  wire logic firstCond = twoLevelPcFirst ? pcTerm : addrTerm;
  wire logic secondCond = twoLevelPcFirst ? addrTerm : pcTerm;

  always_comb begin
    state_next = state_reg;
    trigger_next = 1'b0;
    if (cfgWrite) begin
      state_next = ST_ARMED;
    end else if (!twoLevelEnable) begin
      state_next = ST_ARMED;
      trigger_next = oneLevelFire;
    end else begin
      case (state_reg)
        ST_ARMED: begin
          if (firstCond) state_next = ST_FIRST;
        end
        ST_FIRST: begin
          if (secondCond) begin
            state_next = ST_SPENT;
            trigger_next = 1'b1;
          end
        end
        ST_SPENT: begin
          state_next = ST_SPENT;
        end
        default: begin
          state_next = ST_ARMED;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_ARMED;
      trigger_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      trigger_reg <= trigger_next;
    end
  end

  assign debugTrigger = trigger_reg;
  assign trigStage = state_reg;

endmodule

/* File: design/dbc_pkg.sv */
// Purpose: shared constants for the debug breakpoint comparator unit
// Assumes: register select codes are carried on the debug write ports
// Notes: all breakpoint registers are write-only

package dbc_pkg;

  localparam int DBC_AW = 32;
  localparam int DBC_DW = 32;
  localparam int DBC_SELW = 5;
  localparam int DBC_NPC = 4;

  // register select codes on the debug write ports
  localparam logic [4:0] SEL_PC_MASKED = 5'h08;
  localparam logic [4:0] SEL_PC_MASK = 5'h09;
  localparam logic [4:0] SEL_ADDR_LOW = 5'h0c;
  localparam logic [4:0] SEL_ADDR_HIGH = 5'h0d;
  localparam logic [4:0] SEL_DATA_VALUE = 5'h0e;
  localparam logic [4:0] SEL_DATA_MASK = 5'h0f;
  localparam logic [4:0] SEL_PC_VALID1 = 5'h18;
  localparam logic [4:0] SEL_PC_VALID2 = 5'h19;
  localparam logic [4:0] SEL_PC_VALID3 = 5'h1a;

  // reset value of every breakpoint register
  localparam logic [31:0] REG_RESET = 32'h0000_0000;

  // field layout of the unmaskable instr_match_term registers
  localparam int PCV_VALID_BIT = 0;
  localparam logic [31:0] PCV_IGNORE = 32'h0000_0001;

  // address enable bit positions within addrMatchEnables
  localparam int AEN_LOW = 0;
  localparam int AEN_RANGE = 1;
  localparam int AEN_OUTSIDE = 2;

  // local bus access size encoding
  localparam logic [1:0] SIZE_LONG = 2'h0;
  localparam logic [1:0] SIZE_BYTE = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;

  // lane masks: bytes selected by address bits 1 to 0, word halves by bit 1, all lanes for long
  localparam logic [31:0] LANE_B0 = 32'hff00_0000;
  localparam logic [31:0] LANE_B1 = 32'h00ff_0000;
  localparam logic [31:0] LANE_B2 = 32'h0000_ff00;
  localparam logic [31:0] LANE_B3 = 32'h0000_00ff;
  localparam logic [31:0] LANE_WHI = 32'hffff_0000;
  localparam logic [31:0] LANE_WLO = 32'h0000_ffff;
  localparam logic [31:0] LANE_ALL = 32'hffff_ffff;

  // two-level trigger sequencer, gray along the usual path
  typedef enum logic [1:0] {
    ST_ARMED = 2'h0,
    ST_FIRST = 2'h1,
    ST_SPENT = 2'h3
  } dbc_state_e;

endpackage

/* File: design/dbc_pc_cmp.sv */
// Purpose: one program counter breakpoint comparator
// Assumes: pc and breakpoint address are on the core clock
// Notes: purely combinational

`timescale 1ns/100ps

module dbc_pc_cmp
  import dbc_pkg::*;
(
  // compare operands
  input wire logic [DBC_AW-1:0] pcValue,
  input wire logic [DBC_AW-1:0] breakAddr,
  input wire logic [DBC_AW-1:0] ignoreMask,
  // qualification
  input wire logic enable,
  // result
  output logic hit
);

  logic [DBC_AW-1:0] diffBits;

  // a set ignore bit drops that address bit from the compare
  assign diffBits = (pcValue ^ breakAddr) & ~ignoreMask;
  assign hit = enable & (diffBits == '0);

endmodule

/* File: dv/dbc_breakpoint_unit_properties.sv */
// Purpose: port checks of the breakpoint unit trigger
// Assumes: one clock, async active-low reset
// Notes: bound to every unit instance
`timescale 1ns/100ps
module dbc_breakpoint_unit_properties
  import dbc_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // watched inputs
  input wire logic privWrValid,
  input wire logic supervisorMode,
  input wire logic pcMatchEnable,
  input wire logic [2:0] addrMatchEnables,
  input wire logic twoLevelEnable,
  input wire logic cfgWrite,
  input wire logic addrAttrMatch,
  input wire logic pcValid,
  input wire logic busValid,
  // watched outputs
  input wire logic privWrRefused,
  input wire logic debugTrigger,
  input wire logic [1:0] trigStage
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_armed;
    twoLevelEnable && trigStage == ST_ARMED;
  endsequence
  sequence s_fired;
    debugTrigger && $past(twoLevelEnable);
  endsequence
  refuse_flag_a:
    assert property (privWrRefused == (privWrValid && !supervisorMode))
    else $error("refusal flag wrong");
  idle_quiet_a:
    assert property (!pcValid && !busValid |=> !debugTrigger)
    else $error("trigger without activity");
  all_off_a:
    assert property (!pcMatchEnable && addrMatchEnables == 3'h0
      |=> !debugTrigger)
    else $error("trigger with terms off");
  attr_gate_a:
    assert property (!pcMatchEnable && !addrAttrMatch |=> !debugTrigger)
    else $error("trigger without attribute");
  cfg_quiet_a:
    assert property (cfgWrite |=> !debugTrigger)
    else $error("trigger in config cycle");
  first_wait_a:
    assert property (s_armed |=> !debugTrigger)
    else $error("two-level fired from armed");
  spent_quiet_a:
    assert property (twoLevelEnable && trigStage == ST_SPENT
      |=> !debugTrigger)
    else $error("trigger after spent");
  fire_spent_a:
    assert property (s_fired |-> trigStage == ST_SPENT
      && $past(trigStage) == ST_FIRST)
    else $error("two-level fire out of order");
  rearm_cfg_a:
    assert property (cfgWrite && !pcValid && !busValid
      |=> trigStage == ST_ARMED)
    else $error("no rearm on config write");
  stage_code_a:
    assert property (trigStage != 2'h2)
    else $error("illegal stage code");
endmodule
////////////////
bind dbc_breakpoint_unit dbc_breakpoint_unit_properties i_props (
  .ref_clk, .rst_n, .privWrValid, .supervisorMode, .pcMatchEnable,
  .addrMatchEnables, .twoLevelEnable, .cfgWrite, .addrAttrMatch,
  .pcValid, .busValid, .privWrRefused, .debugTrigger, .trigStage
);

/* File: dv/dbc_core_model.sv */
// Purpose: core side model driving pc and local bus
// Assumes: drives 10 ns after the rising edge, one cycle a step
// Notes: released pc, address and data lines show the inverse of the last value; valids drop to 0
`timescale 1ns/100ps
module dbc_core_model
  import dbc_pkg::*;
(
  // clock
  input wire logic ref_clk,
  // program counter
  output logic pcValid,
  output logic [DBC_AW-1:0] pcValue,
  // local bus
  output logic busValid,
  output logic [DBC_AW-1:0] busAddr,
  output logic [1:0] busSize,
  output logic [DBC_DW-1:0] busData
);
  initial begin
    {pcValid, busValid, busSize} = 4'h0;
    {pcValue, busAddr, busData} = '0;
  end
  task automatic step(input logic p, b, input logic [1:0] bs,
      input logic [31:0] pa, ba, bd);
    @(posedge ref_clk);
    #10;
    {pcValid, busValid, busSize} = {p, b, bs};
    {pcValue, busAddr, busData} = {pa, ba, bd};
    @(posedge ref_clk);
    #10;
    {pcValid, busValid} = 2'h0;
    {pcValue, busAddr, busData} = ~{pa, ba, bd};
  endtask
endmodule

/* File: dv/tb.sv */
// Purpose: self-checking bench of the breakpoint unit
// Assumes: 10 MHz clock, inputs driven 10 ns after the edge
// Notes: registers are write-only, seen through the trigger
`timescale 1ns/100ps
module tb
  import dbc_pkg::*;
;
  logic ref_clk, rst_n, privWrValid, supervisorMode, dbgWrValid;
  logic [4:0] privWrSel, dbgWrSel;
  logic [31:0] privWrData, dbgWrData, busAddr, busData, pcValue, m, ofs;
  logic pcMatchInvert, pcMatchEnable, dataMatchInvert, dataMatchEnable;
  logic twoLevelEnable, twoLevelPcFirst, cfgWrite, addrAttrMatch, inr;
  logic pcValid, busValid, privWrRefused, debugTrigger;
  logic [2:0] addrMatchEnables;
  logic [1:0] busSize, trigStage, sz;
  logic [31:0] adr [5] = '{32'h0ff, 32'h100, 32'h150, 32'h1ff, 32'h200};
  logic [31:0] pat = 32'h1122_3344;
  int fails = 0;
  int n_checks = 0;
  dbc_breakpoint_unit i_dut (.ref_clk, .rst_n, .privWrValid,
    .supervisorMode, .privWrSel, .privWrData, .dbgWrValid, .dbgWrSel,
    .dbgWrData, .pcMatchInvert, .pcMatchEnable, .addrMatchEnables,
    .dataMatchInvert, .dataMatchEnable, .twoLevelEnable, .twoLevelPcFirst,
    .cfgWrite, .addrAttrMatch, .pcValid, .pcValue, .busValid, .busAddr,
    .busSize, .busData, .privWrRefused, .debugTrigger, .trigStage);
  dbc_core_model i_core (.ref_clk, .pcValid, .pcValue, .busValid,
    .busAddr, .busSize, .busData);
  always #50 ref_clk = ~ref_clk;
  task automatic end_sim();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [1:0] exp, got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic dbg, sup, input logic [4:0] s,
      input logic [31:0] d);
    @(posedge ref_clk);
    #10;
    {dbgWrValid, privWrValid, supervisorMode} = {dbg, !dbg, sup};
    {dbgWrSel, privWrSel, dbgWrData, privWrData} = {s, s, d, d};
    #1 chk("refused", {1'b0, !dbg && !sup}, privWrRefused);
    @(posedge ref_clk);
    #10;
    {dbgWrValid, privWrValid} = 2'h0;
    {dbgWrData, privWrData} = ~{d, d};
  endtask
  task automatic pc(input logic [31:0] a, input logic e);
    i_core.step(1'b1, 1'b0, SIZE_LONG, a, ~a, ~a);
    chk("trigger", {1'b0, e}, debugTrigger);
  endtask
  task automatic bus(input logic [31:0] a, input logic [1:0] s,
      input logic [31:0] d, input logic e);
    i_core.step(1'b0, 1'b1, s, ~a, a, d);
    chk("trigger", {1'b0, e}, debugTrigger);
  endtask
  ////////////////
  initial begin
    {ref_clk, rst_n, privWrValid, supervisorMode, dbgWrValid} = 5'h0;
    {privWrSel, dbgWrSel, privWrData, dbgWrData} = '0;
    {pcMatchInvert, pcMatchEnable, addrMatchEnables, cfgWrite} = 6'h0;
    {dataMatchInvert, dataMatchEnable, twoLevelEnable} = 3'h0;
    {twoLevelPcFirst, addrAttrMatch} = 2'h3;
    repeat (20) @(posedge ref_clk);
    #10 rst_n = 1'b1;
    wr(1, 0, SEL_PC_MASKED, 32'h0000_1000);
    wr(1, 0, SEL_PC_MASK, 32'h0000_00ff);
    pcMatchEnable = 1'b1;
    pc(32'h0000_10f4, 1'b1);
    pc(32'h0000_1100, 1'b0);
    pcMatchInvert = 1'b1;
    pc(32'h0000_1100, 1'b1);
    {pcMatchInvert, pcMatchEnable} = 2'h0;
    pc(32'h0000_1000, 1'b0);
    pcMatchEnable = 1'b1;
    for (int i = 0; i < 3; i++) begin
      m = 32'hff00_2000 + (32'(i) << 8);
      wr(0, 1, SEL_PC_VALID1 + 5'(i), m | 32'h1);
      pc(m, 1'b1);
      pc(m + 32'h4, 1'b0);
    end
    wr(0, 0, SEL_PC_VALID1, 32'h0000_4001);
    pc(32'hff00_2000, 1'b1);
    wr(1, 0, SEL_PC_VALID1, 32'hff00_2000);
    pc(32'hff00_2000, 1'b0);
    pcMatchEnable = 1'b0;
    wr(1, 0, SEL_ADDR_LOW, 32'h0000_0100);
    wr(0, 1, SEL_ADDR_HIGH, 32'h0000_01ff);
    for (int k = 0; k < 3; k++) begin
      addrMatchEnables = 3'h1 << k;
      foreach (adr[j]) begin
        inr = adr[j] >= 32'h100 && adr[j] <= 32'h1ff;
        m = (k == 0) ? 32'(adr[j] == 32'h100) : 32'((k == 1) == inr);
        bus(adr[j], SIZE_LONG, 32'h0, m[0]);
      end
    end
    // inclusive range on, so only the attribute can stop the match
    {addrAttrMatch, addrMatchEnables} = 4'h2;
    bus(32'h150, SIZE_LONG, 32'h0, 1'b0);
    {addrAttrMatch, dataMatchEnable} = 2'h3;
    wr(1, 0, SEL_DATA_VALUE, pat);
    wr(1, 0, SEL_DATA_MASK, 32'h0);
    for (int j = 0; j < 7; j++) begin
      sz = j < 4 ? SIZE_BYTE : j < 6 ? SIZE_WORD : SIZE_LONG;
      ofs = j < 4 ? 32'(j) : j < 6 ? 32'(2 * (j - 4)) : 32'h3;
      m = j < 4 ? 32'hff00_0000 >> (8 * j) : '1;
      m = (j == 4 || j == 5) ? 32'hffff_0000 >> (16 * (j - 4)) : m;
      bus(32'h100 + ofs, sz, (pat & m) | ~m, 1'b1);
      bus(32'h100 + ofs, sz, pat ^ m, 1'b0);
    end
    wr(1, 0, SEL_DATA_MASK, 32'h0000_00ff);
    bus(32'h100, SIZE_LONG, pat ^ 32'h0000_00ff, 1'b1);
    dataMatchInvert = 1'b1;
    bus(32'h100, SIZE_LONG, pat, 1'b0);
    bus(32'h100, SIZE_LONG, pat ^ 32'h100, 1'b1);
    {dataMatchInvert, dataMatchEnable, pcMatchEnable} = 3'h1;
    bus(32'h150, SIZE_LONG, 32'h0, 1'b1);
    pc(32'h0000_1010, 1'b1);
    twoLevelEnable = 1'b1;
    bus(32'h150, SIZE_LONG, 32'h0, 1'b0);
    chk("stage", ST_ARMED, trigStage);
    pc(32'h0000_1010, 1'b0);
    chk("stage", ST_FIRST, trigStage);
    bus(32'h150, SIZE_LONG, 32'h0, 1'b1);
    chk("stage", ST_SPENT, trigStage);
    pc(32'h0000_1010, 1'b0);
    bus(32'h150, SIZE_LONG, 32'h0, 1'b0);
    twoLevelPcFirst = 1'b0;
    @(posedge ref_clk);
    #10 cfgWrite = 1'b1;
    @(posedge ref_clk);
    #10 cfgWrite = 1'b0;
    chk("stage", ST_ARMED, trigStage);
    pc(32'h0000_1010, 1'b0);
    bus(32'h150, SIZE_LONG, 32'h0, 1'b0);
    chk("stage", ST_FIRST, trigStage);
    pc(32'h0000_1010, 1'b1);
    end_sim();
  end
  initial begin
    #200000;
    fails++;
    end_sim();
  end
endmodule
